// *** verilog/rds_slew_ctrl.sv ***
// Overview of operation
// - two anti-phase triangle ramps cross at mid-level twice per cycle.
// - compensation above mid gives boost: S1 on, S2 off, S3/S4 alternate.
// - compensation below mid gives buck: S4 on, S3 off, S1/S2 alternate.
// - after reset the target is upper 0x32 with extension bit clear.
// - the reference spans 0 V to 2.555 V in 10 mV or 5 mV steps.
// - the 9-bit code is upper register bits 8..1 and 03h bit 4, 5 mV each.
// - 07h bits 2..0 select amplifier strength, reset value 101.
// - 02h bits 1..0 select ramp rate 0.6 to 4.8 mV/us, default slowest.
// - reference changes follow the rate, soft start included, except falls under negative current limit and the reset on low enable.
// - the rate is set by the period of the step clock.
// - upward steps pause while the positive current limit is tripped.
// - downward steps use the same step clock and rate.
// - negative current limit during a fall drops the rate limit.
// - enable to middle level walks the reference to zero, registers kept.
// - enable below low threshold stops switching and resets registers.
`default_nettype none
module rds_slew_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_high_in,
  input wire logic en_ldo_in,
  input wire logic [rds_pkg::RAMP_W-1:0] comp_level_in,
  input wire logic pos_ilim_in,
  input wire logic neg_ilim_in,
  input wire rds_pkg::rds_reg_req_s reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic [rds_pkg::CODE_W-1:0] ref_code_out,
  output logic [2:0] gm_select_out,
  output rds_pkg::rds_switch_s switches_out,
  output logic boost_mode_out
);
  localparam logic [rds_pkg::CODE_W-1:0] CODE_ONE = 9'h001;
  localparam logic [rds_pkg::TICK_W-1:0] TICK_ONE = 8'h01;

  rds_pkg::rds_ctrl_s s_r;
  rds_pkg::rds_ctrl_s s_nxt;
  logic [rds_pkg::RAMP_W-1:0] ramp_a;
  logic [rds_pkg::RAMP_W-1:0] ramp_b;
  logic [rds_pkg::CODE_W-1:0] goal;
  logic [rds_pkg::TICK_W-1:0] period;
  logic step_up;
  logic step_down;

  rds_dual_ramp #(.W(rds_pkg::RAMP_W)) u_ramp (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ramp_a_out(ramp_a),
    .ramp_b_out(ramp_b)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    // walk-down and off both aim at zero; the target registers stay put
    if (s_r.state == rds_pkg::ST_RUN) begin
      goal = {s_r.target_upper, s_r.target_lsb};
    end else begin
      goal = '0;
    end
    unique case (s_r.slew_sel)
      2'h0: period = rds_pkg::TICK_W'(rds_pkg::TICK0_CYC);
      2'h1: period = rds_pkg::TICK_W'(rds_pkg::TICK1_CYC);
      2'h2: period = rds_pkg::TICK_W'(rds_pkg::TICK2_CYC);
      2'h3: period = rds_pkg::TICK_W'(rds_pkg::TICK3_CYC);
    endcase
    // step clock: a rate change applies at once to the interval already running
    if (s_r.state == rds_pkg::ST_OFF) begin
      s_nxt.tick_cnt = '0;
    end else if (s_r.tick_cnt >= period - TICK_ONE) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + TICK_ONE;
    end
    step_up = s_r.tick && (s_r.ref_code < goal) && !pos_ilim_in;
    step_down = (s_r.ref_code > goal)
      && (s_r.tick || neg_ilim_in);
    if (step_up) begin
      s_nxt.ref_code = s_r.ref_code + CODE_ONE;
    end else if (step_down) begin
      s_nxt.ref_code = s_r.ref_code - CODE_ONE;
    end
    unique case (s_r.state)
      rds_pkg::ST_OFF: begin
        // soft start always begins from code zero
        if (en_high_in) begin
          s_nxt.state = rds_pkg::ST_RUN;
        end
      end
      rds_pkg::ST_RUN: begin
        if (!en_high_in) begin
          s_nxt.state = rds_pkg::ST_WALKDOWN;
        end
      end
      rds_pkg::ST_WALKDOWN: begin
        if (en_high_in) begin
          s_nxt.state = rds_pkg::ST_RUN;
        end else if (s_r.ref_code == '0) begin
          s_nxt.state = rds_pkg::ST_OFF;
        end
      end
      default: s_nxt.state = rds_pkg::ST_OFF;
    endcase
    if (s_r.state == rds_pkg::ST_OFF) begin
      s_nxt.sw = '0;
      s_nxt.boost = 1'b0;
    end else if (comp_level_in > rds_pkg::RAMP_MID) begin
      s_nxt.boost = 1'b1;
      s_nxt.sw.input_high_switch = 1'b1;
      s_nxt.sw.input_low_switch = 1'b0;
      s_nxt.sw.output_low_switch = comp_level_in > ramp_b;
      s_nxt.sw.output_high_switch = !(comp_level_in > ramp_b);
    end else begin
      s_nxt.boost = 1'b0;
      s_nxt.sw.output_high_switch = 1'b1;
      s_nxt.sw.output_low_switch = 1'b0;
      s_nxt.sw.input_high_switch = comp_level_in > ramp_a;
      s_nxt.sw.input_low_switch = !(comp_level_in > ramp_a);
    end
    if (reg_req_in.wr_en) begin
      unique case (reg_req_in.addr)
        rds_pkg::ADDR_TARGET_UPPER: s_nxt.target_upper = reg_req_in.wdata;
        rds_pkg::ADDR_RAMP_RATE:
          s_nxt.slew_sel = reg_req_in.wdata[rds_pkg::SLEW_HI:0];
        rds_pkg::ADDR_TARGET_LSB:
          s_nxt.target_lsb = reg_req_in.wdata[rds_pkg::TARGET_LSB_BIT];
        rds_pkg::ADDR_GM_SEL:
          s_nxt.gm_sel = reg_req_in.wdata[rds_pkg::GM_HI:0];
        default: ;
      endcase
    end
    unique case (reg_req_in.addr)
      rds_pkg::ADDR_TARGET_UPPER: s_nxt.rdata = s_nxt.target_upper;
      rds_pkg::ADDR_RAMP_RATE: s_nxt.rdata = {6'h00, s_nxt.slew_sel};
      rds_pkg::ADDR_TARGET_LSB: s_nxt.rdata = {3'h0, s_nxt.target_lsb, 4'h0};
      rds_pkg::ADDR_GM_SEL: s_nxt.rdata = {5'h00, s_nxt.gm_sel};
      default: s_nxt.rdata = 8'h00;
    endcase
    // losing the low enable level is a full reset, not a walk-down
    if (!en_ldo_in) begin
      s_nxt = rds_pkg::CTRL_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= rds_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_out = s_r.rdata;
  assign ref_code_out = s_r.ref_code;
  assign gm_select_out = s_r.gm_sel;
  assign switches_out = s_r.sw;
  assign boost_mode_out = s_r.boost;

  property p_boost;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in && s_r.state != rds_pkg::ST_OFF
      && comp_level_in > rds_pkg::RAMP_MID
    |=> switches_out.input_high_switch && !switches_out.input_low_switch
      && boost_mode_out;
  endproperty
  a_boost: assert property (p_boost)
    else $error("boost switch pattern wrong");

  property p_buck;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in && s_r.state != rds_pkg::ST_OFF
      && comp_level_in <= rds_pkg::RAMP_MID
    |=> switches_out.output_high_switch && !switches_out.output_low_switch
      && !boost_mode_out;
  endproperty
  a_buck: assert property (p_buck)
    else $error("buck switch pattern wrong");

  property p_reset_target;
    @(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> s_r.target_upper == rds_pkg::TARGET_UPPER_RST
      && s_r.target_lsb == rds_pkg::TARGET_LSB_RST && ref_code_out == '0;
  endproperty
  a_reset_target: assert property (p_reset_target)
    else $error("reference target not at reset value");

  property p_reset_gm;
    @(posedge clk_in) disable iff (rst_in)
    $past(rst_in) |-> gm_select_out == rds_pkg::GM_RST
      && s_r.slew_sel == rds_pkg::SLEW_RST;
  endproperty
  a_reset_gm: assert property (p_reset_gm)
    else $error("strength or rate field not at reset value");

  property p_one_step;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in |=> (ref_code_out == $past(ref_code_out))
      || (ref_code_out == $past(ref_code_out) + CODE_ONE)
      || (ref_code_out == $past(ref_code_out) - CODE_ONE);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("reference moved more than one code");

  property p_rate_gated;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in && !s_r.tick && !neg_ilim_in |=> $stable(ref_code_out);
  endproperty
  a_rate_gated: assert property (p_rate_gated)
    else $error("reference moved without a step tick");

  property p_tick_gap;
    @(posedge clk_in) disable iff (rst_in)
    s_r.tick |=> !s_r.tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("step ticks closer than the fastest rate");

  property p_pos_limit;
    @(posedge clk_in) disable iff (rst_in)
    pos_ilim_in |=> ref_code_out <= $past(ref_code_out);
  endproperty
  a_pos_limit: assert property (p_pos_limit)
    else $error("reference rose under positive current limit");

  property p_neg_limit;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in && neg_ilim_in && ref_code_out > goal
    |=> ref_code_out == $past(ref_code_out) - CODE_ONE;
  endproperty
  a_neg_limit: assert property (p_neg_limit)
    else $error("fall not immediate under negative current limit");

  property p_walkdown;
    @(posedge clk_in) disable iff (rst_in)
    en_ldo_in && !en_high_in && s_r.state != rds_pkg::ST_OFF
    |=> ref_code_out <= $past(ref_code_out) && s_r.state != rds_pkg::ST_RUN;
  endproperty
  a_walkdown: assert property (p_walkdown)
    else $error("reference rose during walk-down");

  property p_ldo_off;
    @(posedge clk_in) disable iff (rst_in)
    !en_ldo_in |=> switches_out == '0 && ref_code_out == '0
      && s_r.target_upper == rds_pkg::TARGET_UPPER_RST
      && gm_select_out == rds_pkg::GM_RST;
  endproperty
  a_ldo_off: assert property (p_ldo_off)
    else $error("low enable did not stop and reset");

  c_boost: cover property (@(posedge clk_in) disable iff (rst_in)
    boost_mode_out && switches_out.output_low_switch);
  c_buck: cover property (@(posedge clk_in) disable iff (rst_in)
    !boost_mode_out && switches_out.input_high_switch);
  c_reach: cover property (@(posedge clk_in) disable iff (rst_in)
    s_r.state == rds_pkg::ST_RUN
      && ref_code_out == {s_r.target_upper, s_r.target_lsb});
  c_walk_off: cover property (@(posedge clk_in) disable iff (rst_in)
    s_r.state == rds_pkg::ST_WALKDOWN ##1 s_r.state == rds_pkg::ST_OFF);
endmodule : rds_slew_ctrl
`default_nettype wire

// *** common/rds_pkg.sv ***
`default_nettype none
package rds_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // one code step of the reference, in microvolts
  localparam int STEP_UV = 5000;
  // feedback-referred ramp rates, microvolts per microsecond
  localparam int RATE0_UV_US = 600;
  localparam int RATE1_UV_US = 1200;
  localparam int RATE2_UV_US = 2400;
  localparam int RATE3_UV_US = 4800;
  // cycles between reference steps; the step period is rounded down
  localparam int TICK0_CYC = STEP_UV * 1000 / (RATE0_UV_US * CLK_PERIOD_NS);
  localparam int TICK1_CYC = STEP_UV * 1000 / (RATE1_UV_US * CLK_PERIOD_NS);
  localparam int TICK2_CYC = STEP_UV * 1000 / (RATE2_UV_US * CLK_PERIOD_NS);
  localparam int TICK3_CYC = STEP_UV * 1000 / (RATE3_UV_US * CLK_PERIOD_NS);
  localparam int TICK_W = 8;
  localparam int CODE_W = 9;
  localparam int RAMP_W = 8;
  localparam logic [RAMP_W-1:0] RAMP_MID = 8'h80;

  localparam logic [7:0] ADDR_TARGET_UPPER = 8'h01;
  localparam logic [7:0] ADDR_RAMP_RATE = 8'h02;
  localparam logic [7:0] ADDR_TARGET_LSB = 8'h03;
  localparam logic [7:0] ADDR_GM_SEL = 8'h07;
  localparam int TARGET_LSB_BIT = 4;
  localparam int SLEW_HI = 1;
  localparam int GM_HI = 2;

  localparam logic [7:0] TARGET_UPPER_RST = 8'h32;
  localparam logic TARGET_LSB_RST = 1'h0;
  localparam logic [1:0] SLEW_RST = 2'h0;
  localparam logic [2:0] GM_RST = 3'h5;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_WALKDOWN = 2'b10
  } rds_state_e;

  typedef struct packed {
    logic input_high_switch;
    logic input_low_switch;
    logic output_low_switch;
    logic output_high_switch;
  } rds_switch_s;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rds_reg_req_s;

  typedef struct packed {
    rds_state_e state;
    logic [7:0] target_upper;
    logic target_lsb;
    logic [1:0] slew_sel;
    logic [2:0] gm_sel;
    logic [CODE_W-1:0] ref_code;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    rds_switch_s sw;
    logic boost;
    logic [7:0] rdata;
  } rds_ctrl_s;

  localparam rds_ctrl_s CTRL_RST = '{
    state: ST_OFF,
    target_upper: TARGET_UPPER_RST,
    target_lsb: TARGET_LSB_RST,
    slew_sel: SLEW_RST,
    gm_sel: GM_RST,
    ref_code: 9'h000,
    tick_cnt: 8'h00,
    tick: 1'h0,
    sw: 4'h0,
    boost: 1'h0,
    rdata: 8'h00
  };

  typedef struct packed {
    logic down;
    logic [RAMP_W-1:0] level_a;
    logic [RAMP_W-1:0] level_b;
  } rds_ramp_s;
endpackage : rds_pkg
`default_nettype wire

// *** verilog/rds_dual_ramp.sv ***
`default_nettype none
module rds_dual_ramp #(
  parameter int W = rds_pkg::RAMP_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic [W-1:0] ramp_a_out,
  output logic [W-1:0] ramp_b_out
);
  typedef struct packed {
    logic down;
    logic [W-1:0] a;
    logic [W-1:0] b;
  } rds_tri_s;
  localparam logic [W-1:0] TOP = '1;
  localparam logic [W-1:0] BOT = '0;
  localparam logic [W-1:0] ONE = W'(1);

  rds_tri_s s_r;
  rds_tri_s s_nxt;

  // ramp b mirrors ramp a, so the two sit half a cycle apart and meet
  // at the midpoint once on the way up and once on the way down
  always_comb begin
    s_nxt = s_r;
    if (!s_r.down) begin
      s_nxt.a = s_r.a + ONE;
      if (s_r.a == TOP - ONE) begin
        s_nxt.down = 1'b1;
      end
    end else begin
      s_nxt.a = s_r.a - ONE;
      if (s_r.a == BOT + ONE) begin
        s_nxt.down = 1'b0;
      end
    end
    s_nxt.b = ~s_nxt.a;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '{down: 1'b0, a: BOT, b: TOP};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ramp_a_out = s_r.a;
  assign ramp_b_out = s_r.b;

  property p_antiphase;
    @(posedge clk_in) disable iff (rst_in)
    (ramp_a_out ^ ramp_b_out) == TOP;
  endproperty
  a_antiphase: assert property (p_antiphase)
    else $error("ramps are not in anti-phase");

  // a wrap instead of a turn would break the two mid-level crossings
  property p_ramp_turn;
    @(posedge clk_in) disable iff (rst_in)
    ramp_a_out == TOP || ramp_a_out == BOT
    |=> ramp_a_out == TOP - ONE || ramp_a_out == BOT + ONE;
  endproperty
  a_ramp_turn: assert property (p_ramp_turn)
    else $error("ramp did not turn at its end point");
endmodule : rds_dual_ramp
`default_nettype wire

// *** tb/rds_host_model.sv ***
`default_nettype none
module rds_host_model (
  input wire logic clk_in,
  output var rds_pkg::rds_reg_req_s reg_req_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_req_out = '{wr_en: 1'b0, addr: 8'h00, wdata: 8'h00};
  end

  // strobe stays up so that back-to-back writes need no gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req_out = '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    #1;
  endtask : wr

  // released data is inverted so a stale value never looks valid
  task automatic idle();
    reg_req_out.wr_en = 1'b0;
    reg_req_out.wdata = ~reg_req_out.wdata;
  endtask : idle

  task automatic rd(input logic [7:0] a);
    reg_req_out.addr = a;
  endtask : rd
endmodule : rds_host_model
`default_nettype wire

// *** tb/tb_rds_slew_ctrl.sv ***
`default_nettype none
module tb_rds_slew_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ADDRS [5] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h05};
  localparam logic [7:0] RSTV [5] = '{8'h32, 8'h00, 8'h00, 8'h05, 8'h00};
  localparam logic [7:0] MASK [5] = '{8'hFF, 8'h03, 8'h10, 8'h07, 8'h00};
  logic clk_in, rst_in, en_high_in, en_ldo_in, pos_ilim_in, neg_ilim_in;
  logic [7:0] comp_level_in;
  logic [7:0] reg_rdata_out;
  logic [8:0] ref_code_out;
  logic [2:0] gm_select_out;
  rds_pkg::rds_switch_s switches_out;
  rds_pkg::rds_switch_s sw;
  logic boost_mode_out;
  rds_pkg::rds_reg_req_s reg_req;
  logic [17:0] q [$];
  logic [31:0] seed = 32'hA8C01DBD;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  rds_host_model HOST (.clk_in(clk_in), .reg_req_out(reg_req));
  rds_slew_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in),
    .en_high_in(en_high_in), .en_ldo_in(en_ldo_in),
    .comp_level_in(comp_level_in), .pos_ilim_in(pos_ilim_in),
    .neg_ilim_in(neg_ilim_in), .reg_req_in(reg_req),
    .reg_rdata_out(reg_rdata_out), .ref_code_out(ref_code_out),
    .gm_select_out(gm_select_out), .switches_out(switches_out),
    .boost_mode_out(boost_mode_out));

  assign sw = switches_out;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // switch view: mode, both pair toggles, then the pair that must be 1,0
  function automatic logic [15:0] seen(input logic [1:0] sel);
    case (sel)
      2'h0: return {8'h00, reg_rdata_out};
      2'h1: return {7'h00, ref_code_out};
      2'h2: return {13'h0000, gm_select_out};
      default: return {11'h000, boost_mode_out,
        sw.input_high_switch ^ sw.input_low_switch,
        sw.output_low_switch ^ sw.output_high_switch,
        boost_mode_out ? {sw.input_high_switch, sw.input_low_switch} :
        {sw.output_high_switch, sw.output_low_switch}};
    endcase
  endfunction : seen

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step

  // a note is compared against the outputs as they stand now
  task automatic note(input logic [1:0] sel, input logic [15:0] exp);
    q.push_back({sel, exp});
    step();
  endtask : note

  task automatic wait_change();
    logic [8:0] v;
    v = ref_code_out;
    for (int i = 0; i < 400 && ref_code_out === v; i++) step();
  endtask : wait_change

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (q.size() > 0) begin
      check_val(seen(q[0][17:16]), q[0][15:0]);
      void'(q.pop_front());
    end
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    int p;
    int n;
    logic [8:0] v;
    logic [7:0] g;
    rst_in = 1'b1;
    en_high_in = 1'b0;
    en_ldo_in = 1'b1;
    pos_ilim_in = 1'b0;
    neg_ilim_in = 1'b0;
    comp_level_in = 8'h80;
    repeat (5) step();
    rst_in = 1'b0;
    for (int i = 0; i < 5; i++) begin
      HOST.rd(ADDRS[i]);
      step();
      note(2'h0, {8'h00, RSTV[i]});
    end
    note(2'h2, 16'h0005);
    note(2'h1, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      g = seed[7:0];
      HOST.wr(ADDRS[i], g);
      HOST.idle();
      note(2'h0, {8'h00, g & MASK[i]});
      if (i == 3) note(2'h2, {13'h0000, g[2:0]});
    end
    for (int s = 0; s < 4; s++) begin
      p = 100000 / (600 << s);
      HOST.wr(8'h02, 8'(s));
      HOST.wr(8'h01, 8'h01);
      HOST.wr(8'h03, 8'h10);
      HOST.idle();
      en_high_in = 1'b1;
      wait_change();
      repeat (p - 1) step();
      note(2'h1, 16'h0001);
      note(2'h1, 16'h0002);
      repeat (p + 2) step();
      note(2'h1, 16'h0003);
      en_high_in = 1'b0;
      wait_change();
      repeat (p - 1) step();
      note(2'h1, 16'h0002);
      note(2'h1, 16'h0001);
      repeat (p + 2) step();
      note(2'h1, 16'h0000);
      note(2'h3, 16'h0000);
      HOST.rd(8'h01);
      step();
      note(2'h0, 16'h0001);
    end
    HOST.wr(8'h01, 8'h05);
    HOST.wr(8'h03, 8'h00);
    HOST.idle();
    pos_ilim_in = 1'b1;
    en_high_in = 1'b1;
    repeat (60) step();
    note(2'h1, 16'h0000);
    pos_ilim_in = 1'b0;
    wait_change();
    note(2'h1, 16'h0001);
    repeat (240) step();
    note(2'h1, 16'h000A);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      comp_level_in = seed[7:0];
      repeat (3) step();
      note(2'h3, (seed[7:0] > 8'h80) ? 16'h001E : 16'h000E);
    end
    comp_level_in = 8'hC0;
    n = 0;
    for (int i = 0; i < 520; i++) begin
      step();
      n += int'(sw.output_low_switch);
    end
    check_val({15'h0000, n > 0 && n < 520}, 16'h0001);
    HOST.wr(8'h01, 8'h00);
    HOST.idle();
    neg_ilim_in = 1'b1;
    wait_change();
    v = ref_code_out;
    step();
    note(2'h1, {7'h00, v - 9'h001});
    note(2'h1, {7'h00, v - 9'h002});
    neg_ilim_in = 1'b0;
    HOST.wr(8'h01, 8'h05);
    HOST.idle();
    repeat (250) step();
    en_ldo_in = 1'b0;
    step();
    note(2'h3, 16'h0000);
    note(2'h1, 16'h0000);
    en_ldo_in = 1'b1;
    HOST.rd(8'h01);
    step();
    note(2'h0, 16'h0032);
    repeat (2) step();
    end_of_test();
  end
endmodule : tb_rds_slew_ctrl
`default_nettype wire
